// ==== rtl/flash_range_defs.vh ====
// register offsets, field positions and reset values of the range block
`ifndef FLASH_RANGE_DEFS_VH
`define FLASH_RANGE_DEFS_VH

// register byte offsets (word aligned)
`define OFS_START_UPPER   6'h00
`define OFS_START_LOWER   6'h04
`define OFS_END_UPPER     6'h08
`define OFS_END_LOWER     6'h0c
`define OFS_SEC_MONITOR   6'h10
`define OFS_SHIELD_START  6'h14
`define OFS_SHIELD_END    6'h18
`define OFS_SEC_SOURCE    6'h1c
`define OFS_OP_CTRL       6'h20
`define OFS_OP_STATUS     6'h24
`define OFS_OP_ADDR       6'h28

// security monitor field positions
`define SEC_WRITE_BIT     12
`define SEC_ERASE_BIT     10
`define SEC_BOOTPROT_BIT  9
`define SEC_BOOTAREA_BIT  8
`define SEC_VALID_MASK    16'h1700

// block geometry: 1 Kbyte blocks, ten bit block number
`define BLOCK_SHIFT       10
`define BLOCK_NUM_MASK    10'h3ff
`define BLOCK_END_MASK    16'h03ff
`define UPPER_MASK        4'hf

// operation codes in the control register
`define OP_NONE           2'h0
`define OP_ERASE          2'h1
`define OP_BLANK          2'h2
`define OP_PROGRAM        2'h3

// reset values
`define RST_UPPER         4'h0
`define RST_LOWER         16'h0000
`define RST_SEC           16'h1700
`define RST_BLOCK         10'h000

`endif

// ==== rtl/range_walker.v ====
// address walker stepping from the start pointer to the end pointer
`timescale 1ns/1ps
`default_nettype none
`include "flash_range_defs.vh"

module range_walker (
    input  wire        clk_i,     // core clock
    input  wire        rst_i,     // synchronous reset
    input  wire        start_i,   // one-cycle launch pulse
    input  wire [19:0] first_i,   // first address
    input  wire [19:0] last_i,    // last address, inclusive
    output reg         busy_o,    // walk in progress
    output reg         done_o,    // one-cycle end pulse
    output reg  [19:0] addr_o     // current address
);

    // walk one address per clock, last address included
    always @(posedge clk_i) begin
        if (rst_i) begin
            busy_o <= 1'b0;
            done_o <= 1'b0;
            addr_o <= 20'h00000;
        end else begin
            done_o <= 1'b0;
            if (start_i && !busy_o) begin
                busy_o <= 1'b1;
                addr_o <= first_i;
            end else if (busy_o) begin
                // stop on equal or beyond, so a reversed range ends after its first address
                if (addr_o >= last_i) begin
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                end else begin
                    addr_o <= addr_o + 20'h00001;
                end
            end
        end
    end

endmodule // range_walker
`default_nettype wire

// ==== rtl/flash_range_regs.v ====
// range pointers, security flag monitor and shield window registers
//
// Overview of operation
// - start address is upper 4-bit pointer over lower 16-bit pointer
// - end address is upper 4-bit end over lower 16-bit end
// - erase and blank check work on 1 Kbyte blocks, offset block<<10
// - write-protect bit 12 at zero refuses programming
// - erase-protect bit 10 at zero refuses block erase
// - boot-protect bit 9 at zero skips the strobes of shield window blocks
// - boot-area bit 8: zero selects cluster one, one cluster zero
// - shield end holds last block plus one, start holds first block
`timescale 1ns/1ps
`default_nettype none
`include "flash_range_defs.vh"

module flash_range_regs (
    input  wire        clk_i,          // core clock, 250 MHz
    input  wire        rst_i,          // synchronous reset, active high
    input  wire        cyc_i,          // wishbone cycle
    input  wire        stb_i,          // wishbone strobe
    input  wire        we_i,           // wishbone write enable
    input  wire [5:0]  adr_i,          // wishbone byte address
    input  wire [3:0]  sel_i,          // wishbone byte selects
    input  wire [31:0] dat_i,          // wishbone write data
    output reg  [31:0] dat_o,          // wishbone read data
    output reg         ack_o,          // wishbone acknowledge
    output reg         err_o,          // wishbone error, unmapped address
    output reg         op_busy_o,      // flash operation running
    output reg         op_strobe_o,    // one address of operation valid
    output reg  [19:0] op_addr_o,      // address under operation
    output reg  [1:0]  op_kind_o,      // operation code in progress
    output reg         boot_cluster_o, // active boot cluster number
    output reg         in_shield_o     // current address inside window
);

    // pointer registers
    reg  [3:0]  start_upper;
    reg  [15:0] start_lower;
    reg  [3:0]  end_upper;
    reg  [15:0] end_lower;
    // security flags as loaded by the extra area logic
    reg  [15:0] sec_monitor;
    reg  [9:0]  shield_start;
    reg  [9:0]  shield_end;
    // sticky refusal flags and operation bookkeeping
    reg         refused;
    reg         op_done;
    reg  [1:0]  op_kind;
    reg         launch;

    wire        req;
    wire        wr;
    wire        rd;
    wire        walk_busy;
    wire        walk_done;
    wire [19:0] walk_addr;
    wire [19:0] first_addr;
    wire [19:0] last_addr;
    wire        mapped;
    wire        allowed;
    wire [9:0]  walk_block;

    // merge one byte lane group into a 16-bit register
    function [15:0] merge16;
        input [15:0] old;
        input [15:0] wdat;
        input [1:0]  sel;
        begin
            merge16 = {sel[1] ? wdat[15:8] : old[15:8],
                       sel[0] ? wdat[7:0]  : old[7:0]};
        end
    endfunction

    // true when a block number falls inside the shield window
    function in_window;
        input [9:0] blk;
        input [9:0] first;
        input [9:0] past;
        begin
            in_window = (blk >= first) && (blk < past);
        end
    endfunction

    assign req  = cyc_i && stb_i && !ack_o && !err_o;
    assign wr   = req && we_i;
    assign rd   = req && !we_i;

    assign first_addr = {start_upper, start_lower};
    assign last_addr  = {end_upper, end_lower};
    assign walk_block = walk_addr[`BLOCK_SHIFT+9:`BLOCK_SHIFT];

    assign mapped = (adr_i == `OFS_START_UPPER) ||
                    (adr_i == `OFS_START_LOWER) ||
                    (adr_i == `OFS_END_UPPER)   ||
                    (adr_i == `OFS_END_LOWER)   ||
                    (adr_i == `OFS_SEC_MONITOR) ||
                    (adr_i == `OFS_SHIELD_START) ||
                    (adr_i == `OFS_SHIELD_END)  ||
                    (adr_i == `OFS_SEC_SOURCE)  ||
                    (adr_i == `OFS_OP_CTRL)     ||
                    (adr_i == `OFS_OP_STATUS)   ||
                    (adr_i == `OFS_OP_ADDR);

    // protection check on the requested operation code
    assign allowed =
        (dat_i[1:0] == `OP_ERASE)   ? sec_monitor[`SEC_ERASE_BIT] :
        (dat_i[1:0] == `OP_PROGRAM) ? sec_monitor[`SEC_WRITE_BIT] :
        (dat_i[1:0] == `OP_BLANK);

    // bus handshake: one wait state, ack or err for one cycle
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            err_o <= 1'b0;
        end else begin
            ack_o <= req && mapped;
            err_o <= req && !mapped;
        end
    end

    // pointer and window registers; held until software rewrites them
    always @(posedge clk_i) begin
        if (rst_i) begin
            start_upper  <= `RST_UPPER;
            start_lower  <= `RST_LOWER;
            end_upper    <= `RST_UPPER;
            end_lower    <= `RST_LOWER;
            sec_monitor  <= `RST_SEC;
            shield_start <= `RST_BLOCK;
            shield_end   <= `RST_BLOCK;
        end else if (wr && !walk_busy) begin
            case (adr_i)
                `OFS_START_UPPER: begin
                    if (sel_i[0]) start_upper <= dat_i[3:0] & `UPPER_MASK;
                end
                `OFS_START_LOWER: begin
                    start_lower <= merge16(start_lower, dat_i[15:0],
                                           sel_i[1:0]);
                end
                `OFS_END_UPPER: begin
                    if (sel_i[0]) end_upper <= dat_i[3:0] & `UPPER_MASK;
                end
                `OFS_END_LOWER: begin
                    end_lower <= merge16(end_lower, dat_i[15:0],
                                         sel_i[1:0]);
                end
                `OFS_SHIELD_START: begin
                    if (sel_i[1:0] == 2'h3)
                        shield_start <= dat_i[9:0] & `BLOCK_NUM_MASK;
                end
                `OFS_SHIELD_END: begin
                    if (sel_i[1:0] == 2'h3)
                        shield_end <= dat_i[9:0] & `BLOCK_NUM_MASK;
                end
                // flags stand in for the extra area contents
                `OFS_SEC_SOURCE: begin
                    sec_monitor <= merge16(sec_monitor, dat_i[15:0],
                                           sel_i[1:0]) & `SEC_VALID_MASK;
                end
                default: begin
                end
            endcase
        end
    end

    // operation launch with protection check; refused requests stick
    always @(posedge clk_i) begin
        if (rst_i) begin
            launch  <= 1'b0;
            refused <= 1'b0;
            op_done <= 1'b0;
            op_kind <= `OP_NONE;
        end else begin
            launch <= 1'b0;
            if (wr && adr_i == `OFS_OP_CTRL && sel_i[0] && !walk_busy &&
                    !launch && dat_i[1:0] != `OP_NONE) begin
                op_done <= 1'b0;
                if (allowed) begin
                    launch  <= 1'b1;
                    refused <= 1'b0;
                    op_kind <= dat_i[1:0];
                end else begin
                    refused <= 1'b1;
                end
            end
            // set after the clear, so a finishing walk is never lost
            if (walk_done)
                op_done <= 1'b1;
        end
    end

    range_walker u_walker (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .start_i (launch),
        .first_i (first_addr),
        .last_i  (last_addr),
        .busy_o  (walk_busy),
        .done_o  (walk_done),
        .addr_o  (walk_addr)
    );

    // registered outputs toward the flash array
    always @(posedge clk_i) begin
        if (rst_i) begin
            op_busy_o      <= 1'b0;
            op_strobe_o    <= 1'b0;
            op_addr_o      <= 20'h00000;
            op_kind_o      <= `OP_NONE;
            boot_cluster_o <= 1'b0;
            in_shield_o    <= 1'b0;
        end else begin
            // busy tracks the walker so it lines up with the address
            op_busy_o   <= walk_busy;
            // shield window blocks skipped when boot protection is clear
            op_strobe_o <= walk_busy &&
                !(!sec_monitor[`SEC_BOOTPROT_BIT] &&
                  in_window(walk_block, shield_start, shield_end));
            op_addr_o   <= walk_addr;
            op_kind_o   <= walk_busy ? op_kind : `OP_NONE;
            // zero picks cluster one, one picks cluster zero
            boot_cluster_o <= ~sec_monitor[`SEC_BOOTAREA_BIT];
            in_shield_o <= in_window(walk_block, shield_start, shield_end);
        end
    end

    // read mux, unused bits read zero
    always @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h00000000;
        end else if (rd) begin
            case (adr_i)
                `OFS_START_UPPER:  dat_o <= {28'h0000000, start_upper};
                `OFS_START_LOWER:  dat_o <= {16'h0000, start_lower};
                `OFS_END_UPPER:    dat_o <= {28'h0000000, end_upper};
                `OFS_END_LOWER:    dat_o <= {16'h0000, end_lower};
                `OFS_SEC_MONITOR:  dat_o <= {16'h0000, sec_monitor};
                `OFS_SEC_SOURCE:   dat_o <= {16'h0000, sec_monitor};
                `OFS_SHIELD_START: dat_o <= {22'h000000, shield_start};
                `OFS_SHIELD_END:   dat_o <= {22'h000000, shield_end};
                `OFS_OP_CTRL:      dat_o <= {30'h00000000, op_kind};
                `OFS_OP_STATUS:    dat_o <= {29'h00000000, refused,
                                             op_done, walk_busy};
                `OFS_OP_ADDR:      dat_o <= {12'h000, walk_addr};
                default:           dat_o <= 32'h00000000;
            endcase
        end
    end

endmodule // flash_range_regs
`default_nettype wire

// ==== bench/flash_range_assertions.sv ====
// assertion checker for the flash range register block
`timescale 1ns/1ps
`default_nettype none
`include "flash_range_defs.vh"
module flash_range_checker (
    input wire logic        clk_i,          // core clock
    input wire logic        rst_i,          // sync reset
    input wire logic        cyc_i,          // bus cycle
    input wire logic        stb_i,          // bus strobe
    input wire logic        we_i,           // bus write
    input wire logic [5:0]  adr_i,          // bus address
    input wire logic [3:0]  sel_i,          // byte selects
    input wire logic [31:0] dat_i,          // write data
    input wire logic [31:0] dat_o,          // read data
    input wire logic        ack_o,          // acknowledge
    input wire logic        err_o,          // bus error
    input wire logic        op_busy_o,      // operation running
    input wire logic        op_strobe_o,    // address valid
    input wire logic [19:0] op_addr_o,      // current address
    input wire logic [1:0]  op_kind_o,      // operation code
    input wire logic        boot_cluster_o, // boot cluster
    input wire logic        in_shield_o     // inside window
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // a request the slave has not answered yet
    wire logic req = cyc_i && stb_i && !ack_o && !err_o;
    wire logic src_wr = req && we_i && adr_i == `OFS_SEC_SOURCE && sel_i[1];

    ack_time_a:
        assert property (req |=> ack_o || err_o) else $error("late answer");
    ack_once_a:
        assert property (ack_o |=> !ack_o) else $error("ack too long");
    err_once_a:
        assert property (err_o |=> !err_o) else $error("err too long");
    resp_excl_a:
        assert property (!(ack_o && err_o)) else $error("ack with err");
    // flag change: write lands, output follows, then it is sampled
    boot_sel_a:
        assert property (src_wr && !op_busy_o |-> ##3
            boot_cluster_o != $past(dat_i[8], 3)) else $error("boot cluster");
    strobe_busy_a:
        assert property (op_strobe_o |-> op_busy_o) else $error("idle strobe");
    addr_step_a:
        assert property (op_busy_o && $past(op_busy_o) |->
            op_addr_o == $past(op_addr_o) + 20'h1) else $error("address step");
    kind_hold_a:
        assert property (op_busy_o && $past(op_busy_o) |-> $stable(op_kind_o))
            else $error("kind changed");
    kind_valid_a:
        assert property ($rose(op_busy_o) |-> op_kind_o != 2'h0)
            else $error("no kind");
    cover property ($rose(op_busy_o));
    cover property (err_o);
    cover property (op_busy_o && in_shield_o && !op_strobe_o);
endmodule // flash_range_checker
bind flash_range_regs flash_range_checker i_chk (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
    .op_busy_o(op_busy_o), .op_strobe_o(op_strobe_o), .op_addr_o(op_addr_o),
    .op_kind_o(op_kind_o), .boot_cluster_o(boot_cluster_o),
    .in_shield_o(in_shield_o));
`default_nettype wire

// ==== bench/testbench.sv ====
// self-checking bench for the flash range register block
`timescale 1ns/1ps
`default_nettype none
`include "flash_range_defs.vh"
module testbench;
    logic        clk_i = 1'b0, rst_i = 1'b1;          // clock and reset
    logic        cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [5:0]  adr_i = 6'h00;
    logic [3:0]  sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0, dat_o, rd, up, lo;
    logic        ack_o, err_o, op_busy_o, op_strobe_o, boot_cluster_o;
    logic        in_shield_o, er, was_busy = 1'b0;
    logic [19:0] op_addr_o, first, last;
    logic [1:0]  op_kind_o;
    logic [9:0]  blk;
    int failures = 0, n_compared = 0, cycles = 0;
    int n_strobe, n_busy, n_shield;
    // rows: address, write data, expected read back
    logic [69:0] rows [8] = '{{`OFS_START_UPPER, 32'h0f, 32'h0f},
        {`OFS_START_LOWER, 32'h1000, 32'h1000}, {`OFS_END_UPPER, 32'h0f, 32'h0f},
        {`OFS_END_LOWER, 32'h13ff, 32'h13ff}, {`OFS_SHIELD_START, 32'h4, 32'h4},
        {`OFS_SHIELD_END, 32'h5, 32'h5}, {`OFS_SEC_MONITOR, 32'h0, 32'h1700},
        {`OFS_SEC_SOURCE, 32'h1700, 32'h1700}};

    flash_range_regs i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o), .op_busy_o(op_busy_o),
        .op_strobe_o(op_strobe_o), .op_addr_o(op_addr_o), .op_kind_o(op_kind_o),
        .boot_cluster_o(boot_cluster_o), .in_shield_o(in_shield_o));

    always #2 clk_i = ~clk_i;
    // watch the operation; values seen here are those sampled at the edge
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin failures++; test_done; end
        if (op_strobe_o) n_strobe++;
        if (in_shield_o) n_shield++;
        if (op_busy_o) begin
            if (!was_busy) first = op_addr_o;
            last = op_addr_o;
            n_busy++;
        end
        was_busy = op_busy_o;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // classic single cycle; request held until the answer is sampled
    task automatic wb(input logic [5:0] a, input logic w, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        int n;
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, a, d, 4'hf};
        n = 0;
        do begin @(posedge clk_i); n++; end while (!(ack_o || err_o) && n < 50);
        if (!(ack_o || err_o)) failures++;
        q = dat_o;
        e = err_o;
        {cyc_i, stb_i, we_i} <= 3'b000;
    endtask
    task automatic run_op(input logic [1:0] k, input int ns, input logic [19:0] f,
        input logic [19:0] l);
        int n;
        {n_strobe, n_busy, n_shield} = '0;
        wb(`OFS_OP_CTRL, 1'b1, {30'h0, k}, rd, er);
        for (n = 0; !op_busy_o && n < 20; n++) @(posedge clk_i);
        wb(`OFS_START_LOWER, 1'b1, 32'hffff, rd, er); // ignored while busy
        for (n = 0; op_busy_o && n < 2000; n++) @(posedge clk_i);
        chk(n_strobe, ns);
        chk(n_busy, 1024);
        chk(first, f);
        chk(last, l);
        wb(`OFS_START_LOWER, 1'b0, 32'h0, rd, er);
        chk(rd, {16'h0, f[15:0]});
        wb(`OFS_OP_STATUS, 1'b0, 32'h0, rd, er);
        chk(rd[1], 1'b1);
    endtask
    // program or erase with its flag at zero must not start
    task automatic refused(input logic [31:0] src, input logic [1:0] k);
        n_busy = 0;
        wb(`OFS_SEC_SOURCE, 1'b1, src, rd, er);
        wb(`OFS_OP_CTRL, 1'b1, {30'h0, k}, rd, er);
        repeat (6) @(posedge clk_i);
        chk(n_busy, 0);
        wb(`OFS_OP_STATUS, 1'b0, 32'h0, rd, er);
        chk(rd[2], 1'b1);
    endtask
    task automatic test_done;
        $display("compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(`OFS_START_LOWER, 1'b0, 32'h0, rd, er);
        chk(rd, 32'h0);
        wb(`OFS_SEC_MONITOR, 1'b0, 32'h0, rd, er);
        chk(rd, 32'h1700);
        chk(boot_cluster_o, {31'h0, ~rd[8]});
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            wb(rows[i][69:64], 1'b1, rows[i][63:32], rd, er);
            wb(rows[i][69:64], 1'b0, 32'h0, rd, er);
            chk(rd, rows[i][31:0]);
        end
        for (int k = 1; k < 4; k++) run_op(k[1:0], 1024, 20'hf1000, 20'hf13ff);
        $display("test data flash done");
        blk = 10'd107;
        up = {28'h0, blk[9:6]};
        lo = {16'h0, blk[5:0], 10'h0};
        wb(`OFS_START_UPPER, 1'b1, up, rd, er);
        wb(`OFS_START_LOWER, 1'b1, lo, rd, er);
        wb(`OFS_END_UPPER, 1'b1, up, rd, er);
        wb(`OFS_END_LOWER, 1'b1, lo | 32'h3ff, rd, er);
        wb(`OFS_SHIELD_START, 1'b1, {22'h0, blk}, rd, er);
        wb(`OFS_SHIELD_END, 1'b1, {22'h0, blk} + 32'h1, rd, er);
        wb(`OFS_SEC_SOURCE, 1'b1, 32'h1500, rd, er);
        run_op(`OP_BLANK, 0, 20'h1ac00, 20'h1afff);
        chk(n_shield > 0, 1'b1);
        wb(`OFS_SEC_SOURCE, 1'b1, 32'h1600, rd, er);
        run_op(`OP_BLANK, 1024, 20'h1ac00, 20'h1afff);
        chk(boot_cluster_o, 1'b1);
        $display("test code flash done");
        refused(32'h0600, `OP_PROGRAM);
        refused(32'h1300, `OP_ERASE);
        $display("test refusal done");
        wb(6'h2c, 1'b0, 32'h0, rd, er);
        chk(er, 1'b1);
        $display("test unmapped done");
        test_done;
    end
endmodule // testbench
`default_nettype wire
